/* gpio_ab_pkg.sv */
package gpio_ab_pkg;
    // Port widths and the lowest change-detection pin
    localparam int PA_W      = 6;
    localparam int PB_W      = 8;
    localparam int PIN_COUNT = PA_W + PB_W;
    localparam int IOC_LO    = 4;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_PORT_A    = 8'h05;
    localparam logic [7:0] IDX_PORT_B    = 8'h06;
    localparam logic [7:0] IDX_OPTION    = 8'h81;
    localparam logic [7:0] IDX_DIR_A     = 8'h85;
    localparam logic [7:0] IDX_DIR_B     = 8'h86;
    localparam logic [7:0] IDX_ANALOG    = 8'h9F;
    localparam logic [7:0] IDX_INT_CTRL  = 8'h0B;
    localparam logic [7:0] IDX_SYS_CTRL  = 8'hA0;

    // Field positions
    localparam int OPT_PULLUP_DIS_N = 7;
    localparam int OPT_EDGE_SEL     = 6;
    localparam int INT_PIN_CHANGE   = 0;
    localparam int INT_EXT          = 1;
    localparam int SYS_LVP          = 0;
    localparam int TMR0_PIN         = 4;
    localparam int SS_PIN           = 5;
    localparam int LVP_EN_PIN       = 3;
    localparam int PROG_CLK_PIN     = 6;
    localparam int PROG_DATA_PIN    = 7;
    localparam int EXT_INT_PIN      = 0;

    // Reset values and the implemented analog config bits
    localparam logic [7:0]      OPTION_RST = 8'hFF;
    localparam logic [PA_W-1:0] DIR_A_RST  = 6'h3F;
    localparam logic [PB_W-1:0] DIR_B_RST  = 8'hFF;
    localparam logic [7:0]      ANALOG_RST = 8'h00;
    localparam logic [7:0]      ANALOG_IMP = 8'h8F;
    localparam logic [PA_W-1:0] LATCH_A_RST = 6'h00;
    localparam logic [PB_W-1:0] LATCH_B_RST = 8'h00;

    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : gpio_ab_pkg

/* gpio_ports_a_b.sv */
// How it works
// RULE_01: Port B is eight bits wide with one direction bit per pin.
// RULE_02: Port B direction one releases the pin; zero drives the latch.
// RULE_03: Option bit 7 low turns on all port B weak pull-ups.
// RULE_04: A port B pin set as output never has its pull-up on.
// RULE_05: Pull-ups are off after power-on reset.
// RULE_06: Change detection covers only input pins among port B 7 to 4.
// RULE_07: Each such pin is compared with its value at the last access.
// RULE_08: Mismatches are ORed and set the change flag, control bit 0.
// RULE_09: The change flag can wake the core from sleep.
// RULE_10: Any read or write of port B refreshes the snapshot.
// RULE_11: A lasting mismatch keeps setting the flag despite clears.
// RULE_12: Software should not poll port B while using change detection.
// RULE_13: Port B pin 0 is an edge interrupt; option bit 6 picks edge.
// RULE_14: Software clears direction bit 3 when programming with pull-ups.
// RULE_15: In low-voltage programming pin 3 enables, pins 6 and 7 serve.
// RULE_16: Port A pin 4 feeds timer 0 clock; its driver is open-drain.
// RULE_17: Port A pin 5 can be the serial port slave select.
// RULE_18: Slave select use needs a digital-capable analog config code.
// RULE_19: Unimplemented bits of port A, direction and config read zero.
// RULE_20: Port A direction one releases the pin; zero drives the latch.
// RULE_21: Port reads give pin levels; writes load the output latch.
// RULE_22: After reset analog port A pins read as zero.
// RULE_23: Pins are synchronised before reads, compares and edge detection.
// RULE_24: An enabled peripheral overrides a port A pin's output path.
//
// Implementation choice: the AHB-Lite slave port.
module gpio_ports_a_b (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    // AHB-Lite slave
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic [31:0]                        hrdata,
    // Port A pins
    input  wire logic [gpio_ab_pkg::PA_W-1:0]  paIn,
    output logic [gpio_ab_pkg::PA_W-1:0]       paOut,
    output logic [gpio_ab_pkg::PA_W-1:0]       paOeN,
    // Port B pins and pull-up control
    input  wire logic [gpio_ab_pkg::PB_W-1:0]  pbIn,
    output logic [gpio_ab_pkg::PB_W-1:0]       pbOut,
    output logic [gpio_ab_pkg::PB_W-1:0]       pbOeN,
    output logic [gpio_ab_pkg::PB_W-1:0]       pbPullupEn,
    // Peripheral override of port A
    input  wire logic [gpio_ab_pkg::PA_W-1:0]  paPeriphSel,
    input  wire logic [gpio_ab_pkg::PA_W-1:0]  paPeriphOut,
    // Peripheral and core side
    input  wire logic                          coreSleeping,
    output logic                               timer0Clock,
    output logic                               slaveSelectN,
    output logic                               lvProgramEnable,
    output logic                               programClock,
    output logic                               programData,
    output logic                               pinChangeFlag,
    output logic                               extIntFlag,
    output logic                               wakeRequest
);
    import gpio_ab_pkg::*;

    typedef struct packed {
        logic [31:0]      hrdata;
        logic             hreadyout;
        logic             hresp;
        logic             wrValid;
        logic [7:0]       wrIdx;
        logic [PA_W-1:0]  latchA;
        logic [PB_W-1:0]  latchB;
        logic [PA_W-1:0]  dirA;
        logic [PB_W-1:0]  dirB;
        logic [7:0]       option;
        logic [7:0]       analogCfg;
        logic             pcFlag;
        logic             extFlag;
        logic             low_voltage_programming;
        logic [3:0]       snap;
        logic             prevRb0;
        logic [PA_W-1:0]  paOut;
        logic [PA_W-1:0]  paOeN;
        logic [PB_W-1:0]  pbOut;
        logic [PB_W-1:0]  pbOeN;
        logic [PB_W-1:0]  pbPullupEn;
        logic             timer0Clock;
        logic             slaveSelectN;
        logic             lvProgEn;
        logic             progClock;
        logic             progData;
        logic             wake;
    } gpio_state_t;

    localparam gpio_state_t STATE_RST = '{
        hrdata:     32'h0000_0000,
        hreadyout:  1'b1,
        hresp:      1'b0,
        wrValid:    1'b0,
        wrIdx:      8'h00,
        latchA:     LATCH_A_RST,
        latchB:     LATCH_B_RST,
        dirA:       DIR_A_RST,
        dirB:       DIR_B_RST,
        option:     OPTION_RST,
        analogCfg:  ANALOG_RST,
        pcFlag:     1'b0,
        extFlag:    1'b0,
        low_voltage_programming:        1'b0,
        snap:       4'h0,
        prevRb0:    1'b0,
        paOut:      6'h00,
        paOeN:      6'h3F,
        pbOut:      8'h00,
        pbOeN:      8'hFF,
        pbPullupEn: 8'h00,
        timer0Clock:  1'b0,
        slaveSelectN: 1'b1,
        lvProgEn:   1'b0,
        progClock:  1'b0,
        progData:   1'b0,
        wake:       1'b0
    };

    gpio_state_t state_ff;
    gpio_state_t nxt_state;

    // Digital pins of port A per analog config code; RA4 is always digital
    function automatic logic [PA_W-1:0] digitalMaskA(input logic [3:0] cfg);
        logic [PA_W-1:0] mask;
        mask = 6'h10;
        if (cfg[3:1] == 3'h3) begin
            mask = 6'h3F;
        end else if (cfg == 4'h4 || cfg == 4'h5 || cfg == 4'hD) begin
            mask = 6'h30;
        end
        return mask;
    endfunction : digitalMaskA

    // Synchronised pin levels
    pin_sync_if pinBus ();
    logic [PA_W-1:0] paSync;
    logic [PB_W-1:0] pbSync;

    assign pinBus.raw = {pbIn, paIn};
    assign paSync     = pinBus.clean[PA_W-1:0];
    assign pbSync     = pinBus.clean[PIN_COUNT-1:PA_W];

    pin_sync u_pin_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pins     (pinBus.sync)
    ); // RULE_23

    // Bus decode and pin events
    logic            addrTake;
    logic            rdTake;
    logic [7:0]      addrIdx;
    logic            mapped;
    logic            mismatch;
    logic            extEdge;
    logic [PA_W-1:0] digA;

    assign addrTake = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign rdTake   = addrTake && !hwrite;
    assign addrIdx  = haddr[9:2];
    assign mapped   = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    assign digA     = digitalMaskA(state_ff.analogCfg[3:0]);
    // Output pins drop out of the compare through their direction bits
    assign mismatch = |((pbSync[PB_W-1:IOC_LO] ^ state_ff.snap)
                        & state_ff.dirB[PB_W-1:IOC_LO]); // RULE_06 RULE_07
    // Edge select high picks the rising edge
    assign extEdge  = state_ff.option[OPT_EDGE_SEL]
                    ? (pbSync[EXT_INT_PIN] && !state_ff.prevRb0)
                    : (!pbSync[EXT_INT_PIN] && state_ff.prevRb0); // RULE_13

    // Next state
    always_comb begin
        nxt_state           = state_ff;
        nxt_state.hreadyout = 1'b1;
        nxt_state.hresp     = 1'b0;
        nxt_state.wrValid   = addrTake && hwrite && mapped;
        nxt_state.wrIdx     = addrIdx;
        nxt_state.prevRb0   = pbSync[EXT_INT_PIN];

        // Read data is fetched in the address phase, so zero wait states
        if (rdTake) begin
            nxt_state.hrdata = 32'h0000_0000;
            if (!mapped) begin
                nxt_state.hrdata = 32'h0000_0000;
            end else if (addrIdx == IDX_PORT_A) begin
                nxt_state.hrdata[PA_W-1:0] = paSync & digA; // RULE_21 RULE_22
            end else if (addrIdx == IDX_PORT_B) begin
                nxt_state.hrdata[PB_W-1:0] = pbSync; // RULE_21
                nxt_state.snap = pbSync[PB_W-1:IOC_LO]; // RULE_10
            end else if (addrIdx == IDX_OPTION) begin
                nxt_state.hrdata[7:0] = state_ff.option;
            end else if (addrIdx == IDX_DIR_A) begin
                nxt_state.hrdata[PA_W-1:0] = state_ff.dirA; // RULE_19
            end else if (addrIdx == IDX_DIR_B) begin
                nxt_state.hrdata[PB_W-1:0] = state_ff.dirB; // RULE_01
            end else if (addrIdx == IDX_ANALOG) begin
                nxt_state.hrdata[7:0] = state_ff.analogCfg; // RULE_19
            end else if (addrIdx == IDX_INT_CTRL) begin
                nxt_state.hrdata[INT_PIN_CHANGE] = state_ff.pcFlag;
                nxt_state.hrdata[INT_EXT]        = state_ff.extFlag;
            end else if (addrIdx == IDX_SYS_CTRL) begin
                nxt_state.hrdata[SYS_LVP] = state_ff.low_voltage_programming;
            end
        end

        // Write data arrives in the data phase
        if (state_ff.wrValid) begin
            if (state_ff.wrIdx == IDX_PORT_A) begin
                nxt_state.latchA = hwdata[PA_W-1:0]; // RULE_21
            end else if (state_ff.wrIdx == IDX_PORT_B) begin
                nxt_state.latchB = hwdata[PB_W-1:0]; // RULE_21
                nxt_state.snap   = pbSync[PB_W-1:IOC_LO]; // RULE_10
            end else if (state_ff.wrIdx == IDX_OPTION) begin
                nxt_state.option = hwdata[7:0];
            end else if (state_ff.wrIdx == IDX_DIR_A) begin
                nxt_state.dirA = hwdata[PA_W-1:0];
            end else if (state_ff.wrIdx == IDX_DIR_B) begin
                nxt_state.dirB = hwdata[PB_W-1:0];
            end else if (state_ff.wrIdx == IDX_ANALOG) begin
                nxt_state.analogCfg = hwdata[7:0] & ANALOG_IMP; // RULE_19
            end else if (state_ff.wrIdx == IDX_INT_CTRL) begin
                nxt_state.pcFlag  = hwdata[INT_PIN_CHANGE];
                nxt_state.extFlag = hwdata[INT_EXT];
            end else if (state_ff.wrIdx == IDX_SYS_CTRL) begin
                nxt_state.low_voltage_programming = hwdata[SYS_LVP];
            end
        end

        // Hardware sets win over a software clear in the same cycle
        if (mismatch) begin
            nxt_state.pcFlag = 1'b1; // RULE_08 RULE_11
        end
        if (extEdge) begin
            nxt_state.extFlag = 1'b1; // RULE_13
        end
        nxt_state.wake = coreSleeping && state_ff.pcFlag; // RULE_09

        // Port A drivers; pin 4 can only pull low
        for (int i = 0; i < PA_W; i++) begin
            nxt_state.paOut[i] = state_ff.latchA[i];
            nxt_state.paOeN[i] = state_ff.dirA[i]; // RULE_20
            if (paPeriphSel[i]) begin
                nxt_state.paOut[i] = paPeriphOut[i]; // RULE_24
                nxt_state.paOeN[i] = 1'b0;
            end
        end
        nxt_state.paOeN[TMR0_PIN] = nxt_state.paOeN[TMR0_PIN]
                                  || nxt_state.paOut[TMR0_PIN]; // RULE_16
        nxt_state.paOut[TMR0_PIN] = 1'b0; // RULE_16

        // Port B drivers and pull-ups
        nxt_state.pbOut = state_ff.latchB;
        nxt_state.pbOeN = state_ff.dirB; // RULE_02
        if (state_ff.low_voltage_programming) begin
            nxt_state.pbOeN[LVP_EN_PIN] = 1'b1; // RULE_15
        end
        nxt_state.pbPullupEn = {PB_W{!state_ff.option[OPT_PULLUP_DIS_N]}}
                             & state_ff.dirB; // RULE_03 RULE_04

        // Alternate input functions
        nxt_state.timer0Clock  = paSync[TMR0_PIN]; // RULE_16
        nxt_state.slaveSelectN = paSync[SS_PIN] || !digA[SS_PIN]; // RULE_17
        nxt_state.lvProgEn  = state_ff.low_voltage_programming && pbSync[LVP_EN_PIN]; // RULE_15
        nxt_state.progClock = pbSync[PROG_CLK_PIN]; // RULE_15
        nxt_state.progData  = pbSync[PROG_DATA_PIN]; // RULE_15
    end

    // State register; reset leaves pull-ups off
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= STATE_RST; // RULE_05
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from the state register
    assign hreadyout       = state_ff.hreadyout;
    assign hresp           = state_ff.hresp;
    assign hrdata          = state_ff.hrdata;
    assign paOut           = state_ff.paOut;
    assign paOeN           = state_ff.paOeN;
    assign pbOut           = state_ff.pbOut;
    assign pbOeN           = state_ff.pbOeN;
    assign pbPullupEn      = state_ff.pbPullupEn;
    assign timer0Clock     = state_ff.timer0Clock;
    assign slaveSelectN    = state_ff.slaveSelectN;
    assign lvProgramEnable = state_ff.lvProgEn;
    assign programClock    = state_ff.progClock;
    assign programData     = state_ff.progData;
    assign pinChangeFlag   = state_ff.pcFlag;
    assign extIntFlag      = state_ff.extFlag;
    assign wakeRequest     = state_ff.wake;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_pullup_off_on_output;
        (pbPullupEn & ~pbOeN) == 8'h00;
    endproperty
    a_pullup_off_on_output: assert property (p_pullup_off_on_output) // RULE_04
        else $error("pull-up active on a driven port B pin");

    property p_pullup_reset;
        $rose(rst_n) |-> (pbPullupEn == 8'h00);
    endproperty
    a_pullup_reset: assert property (p_pullup_reset) // RULE_05
        else $error("pull-ups on after reset");

    property p_dir_b_drive;
        (state_ff.wrValid && state_ff.wrIdx == IDX_DIR_B)
            |-> ##2 (pbOeN[2:0] == $past(hwdata[2:0], 2));
    endproperty
    a_dir_b_drive: assert property (p_dir_b_drive) // RULE_02
        else $error("port B drivers do not follow direction write");

    property p_mismatch_sets;
        mismatch |=> pinChangeFlag;
    endproperty
    a_mismatch_sets: assert property (p_mismatch_sets) // RULE_08
        else $error("mismatch did not set change flag");

    property p_clear_needs_match;
        $fell(pinChangeFlag) |-> !$past(mismatch);
    endproperty
    a_clear_needs_match: assert property (p_clear_needs_match) // RULE_11
        else $error("change flag cleared during mismatch");

    property p_read_refresh;
        (rdTake && mapped && addrIdx == IDX_PORT_B)
            |=> (state_ff.snap == $past(pbSync[7:4]));
    endproperty
    a_read_refresh: assert property (p_read_refresh) // RULE_10
        else $error("port B read did not refresh snapshot");

    property p_ext_edge;
        extEdge |=> extIntFlag;
    endproperty
    a_ext_edge: assert property (p_ext_edge) // RULE_13
        else $error("external edge missed");

    property p_port_a_upper_zero;
        (rdTake && addrIdx == IDX_PORT_A) |=> (hrdata[31:6] == 26'h0);
    endproperty
    a_port_a_upper_zero: assert property (p_port_a_upper_zero) // RULE_19
        else $error("port A upper bits not zero");

    property p_open_drain;
        !paOeN[TMR0_PIN] |-> !paOut[TMR0_PIN];
    endproperty
    a_open_drain: assert property (p_open_drain) // RULE_16
        else $error("timer pin driven high");

    property p_wake;
        (coreSleeping && pinChangeFlag) |=> wakeRequest;
    endproperty
    a_wake: assert property (p_wake) // RULE_09
        else $error("no wake on change flag");
endmodule : gpio_ports_a_b

/* pin_model.sv */
module pin_model (
    // Clock
    input  wire logic                         core_clk,
    // Design pin drive
    input  wire logic [gpio_ab_pkg::PA_W-1:0] paOut,
    input  wire logic [gpio_ab_pkg::PA_W-1:0] paOeN,
    input  wire logic [gpio_ab_pkg::PB_W-1:0] pbOut,
    input  wire logic [gpio_ab_pkg::PB_W-1:0] pbOeN,
    input  wire logic [gpio_ab_pkg::PB_W-1:0] pbPullupEn,
    // Outside world drive
    input  wire logic [gpio_ab_pkg::PA_W-1:0] extA,
    input  wire logic [gpio_ab_pkg::PA_W-1:0] extAEn,
    input  wire logic [gpio_ab_pkg::PB_W-1:0] extB,
    input  wire logic [gpio_ab_pkg::PB_W-1:0] extBEn,
    // Resolved pin levels
    output logic [gpio_ab_pkg::PA_W-1:0]      paIn,
    output logic [gpio_ab_pkg::PB_W-1:0]      pbIn
);
    timeunit 1ns;
    timeprecision 1ns;
    import gpio_ab_pkg::*;

    logic [gpio_ab_pkg::PA_W-1:0] lastA = '1;
    logic [gpio_ab_pkg::PB_W-1:0] lastB = '1;

    // A released pin settles to the inverse of its last driven level,
    // so a stale value can never pass for a fresh one
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < PA_W; i++) begin
            if (!paOeN[i] || extAEn[i]) begin
                lastA[i] <= paIn[i];
            end
        end
        for (int i = 0; i < PB_W; i++) begin
            if (!pbOeN[i] || extBEn[i] || pbPullupEn[i]) begin
                lastB[i] <= pbIn[i];
            end
        end
    end

    // Port A: no pull-ups; pin 4 is open drain
    always_comb begin
        for (int i = 0; i < PA_W; i++) begin
            if (!paOeN[i]) begin
                paIn[i] = paOut[i];
            end else if (extAEn[i]) begin
                paIn[i] = extA[i];
            end else begin
                paIn[i] = !lastA[i];
            end
        end
    end

    // Port B: driver first, then outside, then weak pull-up
    always_comb begin
        for (int i = 0; i < PB_W; i++) begin
            if (!pbOeN[i]) begin
                pbIn[i] = pbOut[i];
            end else if (extBEn[i]) begin
                pbIn[i] = extB[i];
            end else if (pbPullupEn[i]) begin
                pbIn[i] = 1'b1;
            end else begin
                pbIn[i] = !lastB[i];
            end
        end
    end
endmodule : pin_model

/* pin_sync.sv */
module pin_sync (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Pins in, filtered levels out
    pin_sync_if.sync  pins
);
    import gpio_ab_pkg::*;

    typedef struct packed {
        logic [PIN_COUNT-1:0] stage1;
        logic [PIN_COUNT-1:0] stage2;
        logic [PIN_COUNT-1:0] stage3;
        logic [PIN_COUNT-1:0] clean;
    } sync_state_t;

    sync_state_t state_ff;
    sync_state_t nxt_state;

    // Stage one feeds stage two only; levels settle on two agreeing stages
    always_comb begin
        nxt_state        = state_ff;
        nxt_state.stage1 = pins.raw;
        nxt_state.stage2 = state_ff.stage1;
        nxt_state.stage3 = state_ff.stage2;
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (state_ff.stage2[i] == state_ff.stage3[i]) begin
                nxt_state.clean[i] = state_ff.stage3[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign pins.clean = state_ff.clean;
endmodule : pin_sync

/* pin_sync_if.sv */
interface pin_sync_if;
    logic [gpio_ab_pkg::PIN_COUNT-1:0] raw;
    logic [gpio_ab_pkg::PIN_COUNT-1:0] clean;

    modport user (output raw, input clean);
    modport sync (input raw, output clean);
endinterface : pin_sync_if

/* tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import gpio_ab_pkg::*;

    logic core_clk, rst_n, hsel, hwrite, hreadyout, hresp, coreSleeping;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [PA_W-1:0] paIn, paOut, paOeN, paPeriphSel, paPeriphOut, extA, extAEn;
    logic [PB_W-1:0] pbIn, pbOut, pbOeN, pbPullupEn, extB, extBEn;
    logic timer0Clock, slaveSelectN, lvProgramEnable, programClock;
    logic programData, pinChangeFlag, extIntFlag, wakeRequest;
    int err_total = 0;
    int cmp_count = 0;

    gpio_ports_a_b dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .paIn(paIn), .paOut(paOut),
        .paOeN(paOeN), .pbIn(pbIn), .pbOut(pbOut), .pbOeN(pbOeN),
        .pbPullupEn(pbPullupEn), .paPeriphSel(paPeriphSel),
        .paPeriphOut(paPeriphOut), .coreSleeping(coreSleeping),
        .timer0Clock(timer0Clock), .slaveSelectN(slaveSelectN),
        .lvProgramEnable(lvProgramEnable), .programClock(programClock),
        .programData(programData), .pinChangeFlag(pinChangeFlag),
        .extIntFlag(extIntFlag), .wakeRequest(wakeRequest));

    pin_model pins (.core_clk(core_clk), .paOut(paOut), .paOeN(paOeN),
        .pbOut(pbOut), .pbOeN(pbOeN), .pbPullupEn(pbPullupEn), .extA(extA),
        .extAEn(extAEn), .extB(extB), .extBEn(extBEn), .paIn(paIn),
        .pbIn(pbIn));

    // Clock, 50 ns period
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One single AHB transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic w, input logic [7:0] idx, wd,
                       output logic [7:0] rv);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rv = hrdata[7:0];
    endtask : bus

    task automatic wr(input logic [7:0] idx, wd);
        logic [7:0] d;
        bus(1'b1, idx, wd, d);
    endtask : wr

    task automatic rc(input string nm, input logic [7:0] idx, exp);
        logic [7:0] d;
        bus(1'b0, idx, 8'h00, d);
        chk(nm, d, exp);
    endtask : rc

    // Pins need 4 edges to reach the logic, flags one more
    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : w

    task automatic stop_test;
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // Watchdog well beyond the sequence length
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        stop_test();
    end

    initial begin
        {rst_n, hsel, hwrite, coreSleeping} = 4'h0;
        {haddr, hwdata, htrans} = 66'h0;
        {paPeriphSel, paPeriphOut, extA} = 18'h0;
        extAEn = 6'h3F;
        extB = 8'h00;
        extBEn = 8'h00;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        w(1);
        // Reset state of registers and pin controls
        chk("pullups", pbPullupEn, 8'h00);
        chk("flagRst", {pinChangeFlag, extIntFlag}, 2'h0);
        chk("busRst", {hreadyout, hresp}, 2'h2);
        rc("option", IDX_OPTION, 8'hFF);
        rc("dirA", IDX_DIR_A, 8'h3F);
        rc("dirB", IDX_DIR_B, 8'hFF);
        rc("analog", IDX_ANALOG, 8'h00);
        rc("unmapped", 8'h30, 8'h00);
        // Pull-ups on, low nibble made outputs, pins released outside
        wr(IDX_OPTION, 8'h7F);
        w(2);
        chk("pullAll", pbPullupEn, 8'hFF);
        wr(IDX_DIR_B, 8'hF0);
        wr(IDX_PORT_B, 8'hA5);
        w(2);
        chk("oeB", pbOeN, 8'hF0);
        chk("outB", pbOut[3:0], 4'h5);
        chk("pullOut", pbPullupEn, 8'hF0);
        w(6);
        rc("port_b_pins", IDX_PORT_B, 8'hF5);
        // Change detection on upper inputs only
        extBEn <= 8'hFF;
        wr(IDX_OPTION, 8'hFF);
        wr(IDX_DIR_B, 8'hFF);
        w(6);
        rc("snap", IDX_PORT_B, 8'h00);
        wr(IDX_INT_CTRL, 8'h00);
        w(2);
        chk("noChg", pinChangeFlag, 1'b0);
        extB <= 8'h04;
        w(6);
        chk("lowPin", pinChangeFlag, 1'b0);
        // No port B reads while waiting, so the change is not masked
        extB <= 8'h24;
        w(6);
        chk("chg", pinChangeFlag, 1'b1);
        rc("intRd", IDX_INT_CTRL, 8'h01);
        coreSleeping <= 1'b1;
        w(3);
        chk("wake", wakeRequest, 1'b1);
        coreSleeping <= 1'b0;
        // Clearing alone does not hold while mismatch stands
        wr(IDX_INT_CTRL, 8'h00);
        w(2);
        chk("sticky", pinChangeFlag, 1'b1);
        rc("rdB", IDX_PORT_B, 8'h24);
        wr(IDX_INT_CTRL, 8'h00);
        w(2);
        chk("cleared", pinChangeFlag, 1'b0);
        // A write also refreshes the snapshot
        extB <= 8'h64;
        w(6);
        chk("chg6", pinChangeFlag, 1'b1);
        wr(IDX_PORT_B, 8'h00);
        wr(IDX_INT_CTRL, 8'h00);
        w(2);
        chk("wrClr", pinChangeFlag, 1'b0);
        // External interrupt, rising then falling edge selected
        extB <= 8'h65;
        w(6);
        chk("rise", extIntFlag, 1'b1);
        wr(IDX_INT_CTRL, 8'h00);
        wr(IDX_OPTION, 8'hBF);
        w(2);
        extB <= 8'h64;
        w(6);
        chk("fall", extIntFlag, 1'b1);
        wr(IDX_INT_CTRL, 8'h00);
        extB <= 8'h65;
        w(6);
        chk("noRise", extIntFlag, 1'b0);
        // Low-voltage programming; pin 3 set as output so no pull-up
        extB <= 8'h4D;
        wr(IDX_DIR_B, 8'hF7);
        wr(IDX_SYS_CTRL, 8'h01);
        w(8);
        chk("lvp", lvProgramEnable, 1'b1);
        chk("pgmClk", {programClock, programData}, 2'h2);
        chk("lvpRel", pbOeN[3], 1'b1);
        rc("sysRd", IDX_SYS_CTRL, 8'h01);
        // Port A analog masking and shared functions
        extA <= 6'h1F;
        w(6);
        rc("portAan", IDX_PORT_A, 8'h10);
        chk("ssAn", slaveSelectN, 1'b1);
        chk("t0", timer0Clock, 1'b1);
        wr(IDX_ANALOG, 8'h06);
        w(6);
        rc("portAdig", IDX_PORT_A, 8'h1F);
        chk("ss", slaveSelectN, 1'b0);
        // Mixed code: pins 4 and 5 digital, the rest analog
        wr(IDX_ANALOG, 8'h0D);
        rc("portAmix", IDX_PORT_A, 8'h10);
        chk("ssMix", slaveSelectN, 1'b0);
        wr(IDX_ANALOG, 8'hFF);
        rc("analogImp", IDX_ANALOG, 8'h8F);
        wr(IDX_DIR_A, 8'hEF);
        rc("dirAImp", IDX_DIR_A, 8'h2F);
        wr(IDX_PORT_A, 8'h10);
        w(2);
        chk("odHigh", paOeN[4], 1'b1);
        wr(IDX_PORT_A, 8'h00);
        w(2);
        chk("odLow", {paOeN[4], paOut[4]}, 2'h0);
        // Peripheral takes pin A0 although it is an input
        paPeriphSel <= 6'h01;
        paPeriphOut <= 6'h01;
        w(3);
        chk("periph", {paOeN[0], paOut[0]}, 2'h1);
        stop_test();
    end
endmodule : tb_top
